// >>> core/can_rx_pkg.sv
package can_rx_pkg;

	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;
	localparam int NUM_BANKS = 6;
	localparam int BANK_BYTES = 8;
	localparam int FIFO_DEPTH = 3;
	localparam int KEY_W = 32;
	localparam int PAYLOAD_W = 64;
	localparam int INDEX_W = 8;
	localparam int DLC_W = 4;

	// Stored entry: {match index, length code, identifier bytes, payload}
	localparam int ENT_KEY_LSB = PAYLOAD_W;
	localparam int ENT_DLC_LSB = ENT_KEY_LSB + KEY_W;
	localparam int ENT_IDX_LSB = ENT_DLC_LSB + DLC_W;
	localparam int ENTRY_W = ENT_IDX_LSB + INDEX_W;

	// Register offsets
	localparam logic [ADDR_W-1:0] OFS_MASTER_CTRL = 7'h00;
	localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 7'h01;
	localparam logic [ADDR_W-1:0] OFS_QSTAT = 7'h02;
	localparam logic [ADDR_W-1:0] OFS_BANK_ACTIVE = 7'h03;
	localparam logic [ADDR_W-1:0] OFS_SCALE_LO = 7'h04;
	localparam logic [ADDR_W-1:0] OFS_SCALE_HI = 7'h05;
	localparam logic [ADDR_W-1:0] OFS_MODE_LO = 7'h06;
	localparam logic [ADDR_W-1:0] OFS_MODE_HI = 7'h07;
	localparam logic [ADDR_W-1:0] OFS_MB_INDEX = 7'h08;
	localparam logic [ADDR_W-1:0] OFS_MB_DLC = 7'h09;
	localparam logic [ADDR_W-1:0] OFS_MB_IDENT = 7'h0A;
	localparam logic [ADDR_W-1:0] OFS_MB_DATA = 7'h0E;
	localparam logic [ADDR_W-1:0] OFS_FILTER_BASE = 7'h20;
	localparam logic [ADDR_W-1:0] OFS_FILTER_END = 7'h50;

	// Field positions
	localparam int LOCK_BIT = 0;
	localparam int PEND_IE_BIT = 0;
	localparam int FULL_IE_BIT = 1;
	localparam int OVR_IE_BIT = 2;
	localparam int FULL_BIT = 3;
	localparam int OVR_BIT = 4;
	localparam int RELEASE_BIT = 5;

	// Reset values and full queue count
	localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
	localparam logic [1:0] COUNT_EMPTY = 2'h0;
	localparam logic [1:0] COUNT_FULL = 2'h3;

	typedef enum logic [1:0] {
		SCALE_8X4 = 2'h0,
		SCALE_16_8X2 = 2'h1,
		SCALE_16X2 = 2'h2,
		SCALE_32 = 2'h3
	} scale_t;

	// Width classes used for match preference
	localparam logic [1:0] WCLS_8 = 2'h1;
	localparam logic [1:0] WCLS_16 = 2'h2;
	localparam logic [1:0] WCLS_32 = 2'h3;

endpackage

// >>> core/can_rx_fifo_filter.sv
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// RULE1: Three-entry receive queue run by hardware; host sees only oldest entry.
// RULE2: Frame counts only if error-free to end and accepted by filters.
// RULE3: First valid frame into empty queue is stored; pending count becomes 01b.
// RULE4: Writing release bit drops oldest entry, decrements count, shows next.
// RULE5: Further frames without release raise count to 10b then 11b.
// RULE6: Software must release before a fourth frame or one is lost.
// RULE7: Frame arriving with three held sets overrun flag, one is lost.
// RULE8: Lock clear: overrunning frame overwrites the newest stored entry.
// RULE9: Lock set: overrunning frame is dropped, three oldest kept.
// RULE10: Count 00b to 01b raises request when pending enable is set.
// RULE11: Third stored entry sets full flag, request when full enable set.
// RULE12: Overrun sets flag and raises request when overrun enable set.
// RULE13: Six filter banks of eight bytes, each with its own scale code.
// RULE14: Scale 3: one 32-bit filter over whole identifier and flags.
// RULE15: Scale 2: two 16-bit filters over standard id, remote, extension.
// RULE16: Scale 0: four 8-bit filters over standard id bits 10..3 only.
// RULE17: Scale 1: one 16-bit filter plus two 8-bit filters.
// RULE18: 32-bit byte order: std 10..3; std 2..0,rtr,ide,ext 17..15; ext.
// RULE19: Mask mode pairs identifier with a must-match/don't-care mask.
// RULE20: List mode treats mask bytes as second identifier, exact match.
// RULE21: Matching filter index is stored with the message.
// RULE22: Prefer list over mask, wider over narrower, then lower number.
// RULE23: Frames matching no active filter are dropped silently.
// RULE24: Release with empty queue changes neither count nor flags.
module can_rx_fifo_filter
	import can_rx_pkg::*;
(
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	input wire logic [can_rx_pkg::ADDR_W-1:0] addr_i,
	input wire logic [can_rx_pkg::DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [can_rx_pkg::DATA_W-1:0] rdata_o,
	input wire logic frame_done_i,
	input wire logic frame_err_i,
	input wire logic [10:0] std_id_i,
	input wire logic [17:0] ext_id_i,
	input wire logic ide_i,
	input wire logic rtr_i,
	input wire logic [can_rx_pkg::DLC_W-1:0] dlc_i,
	input wire logic [can_rx_pkg::PAYLOAD_W-1:0] data_i,
	output logic irq_pending_o,
	output logic irq_full_o,
	output logic irq_overrun_o
);
	import can_rx_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Functions

	// Circular slot arithmetic over a three-deep queue
	function automatic logic [1:0] slot(input logic [1:0] p,
		input logic [1:0] k);
		logic [2:0] s;
		s = {1'b0, p} + {1'b0, k};
		if (s >= 3'(FIFO_DEPTH))
			s = s - 3'(FIFO_DEPTH);
		return s[1:0];
	endfunction

	// Best candidate of one bank: {hit, list, width class, register}
	function automatic logic [6:0] bank_pick(input logic [63:0] regs,
		input logic [1:0] scale, input logic ml, input logic mh,
		input logic [KEY_W-1:0] key);
		logic [6:0] best;
		logic list;
		logic [1:0] wcls;
		int n;
		int g;
		logic ok;
		logic cand;
		logic [7:0] idb;
		logic [7:0] mb;
		best = '0;
		for (int j = 0; j < BANK_BYTES; j++) begin
			list = (j < 4) ? ml : mh;
			case (scale)
				SCALE_32: begin // RULE14
					wcls = WCLS_32;
					n = 4;
				end
				SCALE_16X2: begin // RULE15
					wcls = WCLS_16;
					n = 2;
				end
				SCALE_16_8X2: begin // RULE17
					wcls = (j < 4) ? WCLS_16 : WCLS_8;
					n = (j < 4) ? 2 : 1;
				end
				default: begin // RULE16
					wcls = WCLS_8;
					n = 1;
				end
			endcase
			g = j - (j % (2 * n));
			cand = (j == g) || (list && (j == g + n)); // RULE20
			ok = 1'b1;
			for (int b = 0; b < 4; b++) begin
				if (b < n && j + b < BANK_BYTES) begin
					idb = regs[8*(j+b) +: 8];
					// RULE19 RULE20
					mb = list ? 8'hFF : regs[8*((g+n+b) % 8) +: 8];
					if (((key[KEY_W-1-8*b -: 8] ^ idb) & mb) != 8'h00)
						ok = 1'b0;
				end
			end
			// Strictly greater keeps the lower register on a tie
			if (cand && ok && (!best[6] || {list, wcls} > best[5:3])) // RULE22
				best = {1'b1, list, wcls, 3'(j)};
		end
		return best;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Registers and decode

	logic lock_q;
	logic [2:0] irq_en_q;
	logic [NUM_BANKS-1:0] bank_active_q;
	logic [1:0] scale_q [NUM_BANKS];
	logic [NUM_BANKS-1:0] mode_lo_q;
	logic [NUM_BANKS-1:0] mode_hi_q;
	logic [63:0] bank_q [NUM_BANKS]; // RULE13
	logic [1:0] count_q;
	logic [1:0] count_d;
	logic [1:0] head_q;
	logic full_q;
	logic ovr_q;
	logic [ENTRY_W-1:0] mem_q [FIFO_DEPTH];
	logic [DATA_W-1:0] rdata_q;
	logic irq_pending_q;
	logic irq_full_q;
	logic irq_overrun_q;

	logic wr_w;
	logic qstat_wr_w;
	logic filt_sel_w;
	logic [ADDR_W-1:0] filt_off_w;
	logic [KEY_W-1:0] key_w;
	logic hit_w;
	logic [2:0] pref_w;
	logic [INDEX_W-1:0] idx_w;
	logic store_w;
	logic release_w;
	logic overrun_w;
	logic [ENTRY_W-1:0] entry_w;
	logic [ENTRY_W-1:0] out_w;

	assign wr_w = ce_i && wr_i;
	assign qstat_wr_w = wr_w && (addr_i == OFS_QSTAT);
	assign filt_sel_w = (addr_i >= OFS_FILTER_BASE) &&
		(addr_i < OFS_FILTER_END);
	assign filt_off_w = addr_i - OFS_FILTER_BASE;

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			lock_q <= 1'b0;
			irq_en_q <= 3'h0;
			bank_active_q <= '0;
			mode_lo_q <= '0;
			mode_hi_q <= '0;
		end else if (wr_w) begin
			case (addr_i)
				OFS_MASTER_CTRL: lock_q <= wdata_i[LOCK_BIT];
				OFS_IRQ_EN: irq_en_q <= wdata_i[OVR_IE_BIT:PEND_IE_BIT];
				OFS_BANK_ACTIVE: bank_active_q <= wdata_i[NUM_BANKS-1:0];
				OFS_MODE_LO: mode_lo_q <= wdata_i[NUM_BANKS-1:0];
				OFS_MODE_HI: mode_hi_q <= wdata_i[NUM_BANKS-1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			for (int i = 0; i < NUM_BANKS; i++) begin
				scale_q[i] <= SCALE_8X4;
				bank_q[i] <= '0;
			end
		end else if (wr_w) begin
			if (addr_i == OFS_SCALE_LO) begin
				for (int i = 0; i < 4; i++)
					scale_q[i] <= wdata_i[2*i +: 2];
			end
			if (addr_i == OFS_SCALE_HI) begin
				for (int i = 4; i < NUM_BANKS; i++)
					scale_q[i] <= wdata_i[2*(i-4) +: 2];
			end
			if (filt_sel_w)
				bank_q[filt_off_w[5:3]][8*filt_off_w[2:0] +: 8] <= wdata_i;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Acceptance filtering

	// Compared byte order of an incoming identifier
	assign key_w = {std_id_i, rtr_i, ide_i, ext_id_i, 1'b0}; // RULE18

	always_comb begin
		logic [6:0] bp;
		bp = '0;
		hit_w = 1'b0;
		pref_w = '0;
		idx_w = '0;
		for (int b = 0; b < NUM_BANKS; b++) begin
			bp = bank_pick(bank_q[b], scale_q[b], mode_lo_q[b],
				mode_hi_q[b], key_w);
			// RULE22 RULE23
			if (bank_active_q[b] && bp[6] &&
				(!hit_w || bp[5:3] > pref_w)) begin
				hit_w = 1'b1;
				pref_w = bp[5:3];
				idx_w = 8'(b * BANK_BYTES) + {5'h00, bp[2:0]};
			end
		end
	end

	// Preference is kept apart so banks 4 and 5 keep their full index
	assign store_w = ce_i && frame_done_i && !frame_err_i && hit_w; // RULE2
	assign entry_w = {idx_w, dlc_i, key_w, data_i}; // RULE21

	////////////////////////////////////////////////////////////////////////
	// Receive queue

	assign release_w = qstat_wr_w && wdata_i[RELEASE_BIT] &&
		(count_q != COUNT_EMPTY); // RULE4 RULE24
	assign overrun_w = store_w && (count_q == COUNT_FULL) && !release_w;

	always_comb begin
		count_d = count_q;
		if (store_w && !release_w && count_q != COUNT_FULL)
			count_d = count_q + 2'h1; // RULE3 RULE5
		else if (release_w && !store_w)
			count_d = count_q - 2'h1; // RULE4
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			count_q <= COUNT_EMPTY;
			head_q <= 2'h0;
		end else if (ce_i) begin
			count_q <= count_d;
			if (release_w)
				head_q <= slot(head_q, 2'h1); // RULE1 RULE4
		end
	end

	// On release with three held, the tail wraps onto the freed head slot
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			for (int i = 0; i < FIFO_DEPTH; i++)
				mem_q[i] <= '0;
		end else if (store_w) begin
			if (!overrun_w)
				mem_q[slot(head_q, count_q)] <= entry_w; // RULE3 RULE5
			else if (!lock_q)
				mem_q[slot(head_q, 2'h2)] <= entry_w; // RULE8
		end
	end

	// Set wins over a clear written in the same cycle
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			full_q <= 1'b0;
			ovr_q <= 1'b0;
		end else if (ce_i) begin
			if (store_w && count_q == 2'h2 && !release_w)
				full_q <= 1'b1; // RULE11
			else if (qstat_wr_w && wdata_i[FULL_BIT])
				full_q <= 1'b0;
			if (overrun_w)
				ovr_q <= 1'b1; // RULE7 RULE12
			else if (qstat_wr_w && wdata_i[OVR_BIT])
				ovr_q <= 1'b0;
		end
	end

	// Requests are levels held while the cause and enable stand
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			irq_pending_q <= 1'b0;
			irq_full_q <= 1'b0;
			irq_overrun_q <= 1'b0;
		end else if (ce_i) begin
			irq_pending_q <= irq_en_q[PEND_IE_BIT] &&
				(count_d != COUNT_EMPTY); // RULE10
			irq_full_q <= irq_en_q[FULL_IE_BIT] && full_q; // RULE11
			irq_overrun_q <= irq_en_q[OVR_IE_BIT] && ovr_q; // RULE12
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read path

	assign out_w = (count_q == COUNT_EMPTY) ? '0 : mem_q[head_q]; // RULE1

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_q <= RST_BYTE;
		end else if (ce_i && rd_i) begin
			rdata_q <= RST_BYTE;
			if (filt_sel_w)
				rdata_q <= bank_q[filt_off_w[5:3]][8*filt_off_w[2:0] +: 8];
			else if (addr_i >= OFS_MB_IDENT && addr_i < OFS_MB_DATA)
				rdata_q <= out_w[ENT_DLC_LSB-1-8*(addr_i-OFS_MB_IDENT) -: 8];
			else if (addr_i >= OFS_MB_DATA && addr_i < OFS_MB_DATA + 7'h08)
				rdata_q <= out_w[8*(addr_i-OFS_MB_DATA) +: 8];
			else begin
				case (addr_i)
					OFS_MASTER_CTRL: rdata_q[LOCK_BIT] <= lock_q;
					OFS_IRQ_EN: rdata_q[OVR_IE_BIT:PEND_IE_BIT] <= irq_en_q;
					OFS_QSTAT: rdata_q <= {2'b00, 1'b0, ovr_q, full_q, 1'b0,
						count_q};
					OFS_BANK_ACTIVE: rdata_q <= {2'b00, bank_active_q};
					OFS_SCALE_LO: rdata_q <= {scale_q[3], scale_q[2],
						scale_q[1], scale_q[0]};
					OFS_SCALE_HI: rdata_q <= {4'h0, scale_q[5], scale_q[4]};
					OFS_MODE_LO: rdata_q <= {2'b00, mode_lo_q};
					OFS_MODE_HI: rdata_q <= {2'b00, mode_hi_q};
					OFS_MB_INDEX: rdata_q <= out_w[ENT_IDX_LSB +: INDEX_W];
					OFS_MB_DLC: rdata_q <= {4'h0, out_w[ENT_DLC_LSB +: DLC_W]};
					default: rdata_q <= RST_BYTE;
				endcase
			end
		end
	end

	assign rdata_o = rdata_q;
	assign irq_pending_o = irq_pending_q;
	assign irq_full_o = irq_full_q;
	assign irq_overrun_o = irq_overrun_q;

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!nrst_i);

	property p_first_store;
		store_w && count_q == COUNT_EMPTY |=> count_q == 2'h1 &&
			mem_q[head_q] == $past(entry_w);
	endproperty
	a_first_store: assert property (p_first_store) // RULE3
		else $error("first frame not exposed with count 1");

	property p_release;
		release_w && !store_w |=> count_q == $past(count_q) - 2'h1 &&
			head_q == slot($past(head_q), 2'h1);
	endproperty
	a_release: assert property (p_release) // RULE4
		else $error("release did not pop the oldest entry");

	property p_advance;
		store_w && !release_w && (count_q == 2'h1 || count_q == 2'h2)
			|=> count_q == $past(count_q) + 2'h1;
	endproperty
	a_advance: assert property (p_advance) // RULE5
		else $error("pending count did not advance");

	property p_overrun;
		overrun_w |=> ovr_q && count_q == COUNT_FULL && $stable(head_q);
	endproperty
	a_overrun: assert property (p_overrun) // RULE7
		else $error("overrun not flagged");

	property p_no_lock;
		overrun_w && !lock_q |=>
			mem_q[slot(head_q, 2'h2)] == $past(entry_w);
	endproperty
	a_no_lock: assert property (p_no_lock) // RULE8
		else $error("newest entry not overwritten");

	property p_lock;
		overrun_w && lock_q |=> mem_q[0] == $past(mem_q[0]) &&
			mem_q[1] == $past(mem_q[1]) && mem_q[2] == $past(mem_q[2]);
	endproperty
	a_lock: assert property (p_lock) // RULE9
		else $error("locked queue was modified");

	property p_pend_irq;
		store_w && count_q == COUNT_EMPTY && irq_en_q[PEND_IE_BIT]
			|=> irq_pending_o;
	endproperty
	a_pend_irq: assert property (p_pend_irq) // RULE10
		else $error("pending request missing");

	property p_full;
		store_w && count_q == 2'h2 && !release_w ##1 ce_i &&
			irq_en_q[FULL_IE_BIT] |=> irq_full_o;
	endproperty
	a_full: assert property (p_full) // RULE11
		else $error("full flag or request missing");

	property p_ovr_irq;
		overrun_w ##1 ce_i && irq_en_q[OVR_IE_BIT] |=> irq_overrun_o;
	endproperty
	a_ovr_irq: assert property (p_ovr_irq) // RULE12
		else $error("overrun request missing");

	property p_drop;
		ce_i && frame_done_i && (frame_err_i || !hit_w) && !qstat_wr_w
			|=> $stable(count_q) && $stable(ovr_q);
	endproperty
	a_drop: assert property (p_drop) // RULE2
		else $error("rejected frame changed the queue");

	property p_empty_release;
		qstat_wr_w && wdata_i[RELEASE_BIT] && count_q == COUNT_EMPTY &&
			!store_w |=> count_q == COUNT_EMPTY && $stable(head_q);
	endproperty
	a_empty_release: assert property (p_empty_release) // RULE24
		else $error("release on empty queue had an effect");

	c_overrun: cover property (overrun_w);
	c_full: cover property (store_w && count_q == 2'h2);
	c_store_and_release: cover property (store_w && release_w);
	c_list_hit: cover property (store_w && pref_w[2]);

endmodule

`default_nettype wire

// >>> dv/can_frame_source.sv
`timescale 1ns/100ps
`default_nettype none

module can_frame_source (
	input wire logic clock_i,
	output var logic frame_done_o,
	output var logic frame_err_o,
	output var logic [10:0] std_id_o,
	output var logic [17:0] ext_id_o,
	output var logic ide_o,
	output var logic rtr_o,
	output var logic [3:0] dlc_o,
	output var logic [63:0] data_o
);
	initial begin
		frame_done_o = 1'b0;
		frame_err_o = 1'b0;
		{std_id_o, ext_id_o, ide_o, rtr_o, dlc_o, data_o} = '0;
	end

	////////////////////////////////////////////////////////////////////
	// One pulse per finished frame; fields mean something only beside it
	task automatic send(input logic [10:0] s, input logic [17:0] e,
		input logic i, input logic [3:0] l, input logic [63:0] d,
		input logic er);
		@(posedge clock_i);
		frame_done_o <= 1'b1;
		frame_err_o <= er;
		{std_id_o, ext_id_o, ide_o, rtr_o, dlc_o, data_o} <= {s, e, i, 1'b0, l, d};
		@(posedge clock_i);
		frame_done_o <= 1'b0;
		frame_err_o <= ~er;
		// Invert stale fields so nothing can lean on their old values
		{std_id_o, ext_id_o, ide_o, rtr_o, dlc_o, data_o} <= ~{s, e, i, 1'b0, l, d};
	endtask
endmodule
`default_nettype wire

// >>> dv/test_can_rx_fifo_and_id_filter.sv
`timescale 1ns/100ps
`default_nettype none

module test_can_rx_fifo_and_id_filter
	import can_rx_pkg::*;
;
	localparam logic [31:0] KEY1 = {11'h52D, 1'b0, 1'b1, 18'h2ABCD, 1'b0};
	localparam logic [31:0] KEY2 = {11'h123, 1'b0, 1'b0, 18'h00000, 1'b0};
	typedef struct {
		int idx;
		logic [31:0] key;
		logic [3:0] dlc;
		logic [63:0] dat;
	} ent_t;
	logic clock_i = 1'b0;
	logic nrst_i = 1'b0;
	logic ce_i = 1'b1;
	logic [ADDR_W-1:0] addr_i = '0;
	logic [DATA_W-1:0] wdata_i = '0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	wire logic [DATA_W-1:0] rdata_o;
	wire logic irq_pending_o;
	wire logic irq_full_o;
	wire logic irq_overrun_o;
	wire logic fdone;
	wire logic ferr;
	wire logic [10:0] sid;
	wire logic [17:0] eid;
	wire logic ide;
	wire logic rtr;
	wire logic [3:0] dlc;
	wire logic [63:0] dat;
	ent_t q[$];
	int ovr, full, lock, ie, bad_count, n_tests, k;
	logic [7:0] d;

	can_frame_source i_src (.clock_i(clock_i), .frame_done_o(fdone),
		.frame_err_o(ferr), .std_id_o(sid), .ext_id_o(eid), .ide_o(ide),
		.rtr_o(rtr), .dlc_o(dlc), .data_o(dat));

	can_rx_fifo_filter i_dut (.clock_i(clock_i), .nrst_i(nrst_i),
		.ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .frame_done_i(fdone),
		.frame_err_i(ferr), .std_id_i(sid), .ext_id_i(eid), .ide_i(ide),
		.rtr_i(rtr), .dlc_i(dlc), .data_i(dat),
		.irq_pending_o(irq_pending_o), .irq_full_o(irq_full_o),
		.irq_overrun_o(irq_overrun_o));

	always #5 clock_i = ~clock_i;

	////////////////////////////////////////////////////////////////////
	task automatic test_done;
		$display("comparisons %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		repeat (100000) @(posedge clock_i);
		bad_count++;
		test_done;
	end

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic chk_irq(input logic [2:0] g, input logic [2:0] e);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH t=%0t irq got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
		@(posedge clock_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] v);
		@(posedge clock_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1;
		v = rdata_o;
	endtask

	////////////////////////////////////////////////////////////////////
	// Kinds: 0 narrow mask hit, 1 and 2 list hits, 3 no filter hit
	task automatic frame(input int c, input logic er);
		ent_t n;
		logic [17:0] e;
		logic [10:0] s;
		s = c == 0 ? 11'h52F : c == 1 ? 11'h52D : c == 2 ? 11'h123 : 11'h000;
		e = c == 0 ? 18'($urandom) : c == 1 ? 18'h2ABCD : 18'h00000;
		n.idx = c == 0 ? 0 : c == 1 ? 16 : c == 2 ? 20 : -1;
		n.key = {s, 1'b0, c == 1, e, 1'b0};
		n.dlc = 4'($urandom);
		n.dat = {$urandom, $urandom};
		i_src.send(s, e, c == 1, n.dlc, n.dat, er);
		if (!er && n.idx >= 0) begin
			if (q.size() < 3) begin
				q.push_back(n);
				if (q.size() == 3) full = 1;
			end else begin
				ovr = 1;
				if (!lock) q[2] = n;
			end
		end
	endtask

	task automatic rel;
		wr(OFS_QSTAT, 8'h20);
		if (q.size() > 0) void'(q.pop_front());
	endtask

	task automatic status;
		logic [2:0] x;
		rd(OFS_QSTAT, d);
		chk(d, {3'h0, ovr[0], full[0], 1'b0, 2'(q.size())});
		// One spare cycle lets the registered request lines settle
		@(posedge clock_i);
		#1;
		x = {ovr[0], full[0], q.size() > 0} & {3{ie[0]}};
		chk_irq({irq_overrun_o, irq_full_o, irq_pending_o}, x);
	endtask

	task automatic head;
		ent_t h;
		h = '{0, '0, '0, '0};
		if (q.size() > 0) h = q[0];
		rd(OFS_MB_INDEX, d);
		chk(d, 8'(h.idx));
		rd(OFS_MB_DLC, d);
		chk(d, {4'h0, h.dlc});
		for (int j = 0; j < 4; j++) begin
			rd(OFS_MB_IDENT + 7'(j), d);
			chk(d, h.key[31 - 8 * j -: 8]);
		end
		for (int j = 0; j < 8; j++) begin
			rd(OFS_MB_DATA + 7'(j), d);
			chk(d, h.dat[8 * j +: 8]);
		end
	endtask

	////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h711E3C97));
		repeat (20) @(posedge clock_i);
		nrst_i <= 1'b1;
		status;
		rd(7'h60, d);
		chk(d, 8'h00);
		rd(OFS_FILTER_BASE + 7'h18, d);
		chk(d, 8'h00);
		rel;
		status;
		wr(OFS_IRQ_EN, 8'h07);
		ie = 1;
		wr(OFS_BANK_ACTIVE, 8'h05);
		wr(OFS_SCALE_LO, 8'h30);
		wr(OFS_MODE_LO, 8'h04);
		wr(OFS_MODE_HI, 8'h04);
		for (k = 0; k < 8; k++) begin
			wr(OFS_FILTER_BASE + 7'(k), k[0] ? 8'hFF : 8'hA5);
			wr(OFS_FILTER_BASE + 7'(16 + k),
				k < 4 ? KEY1[31 - 8 * k -: 8] : KEY2[63 - 8 * k -: 8]);
		end
		rd(OFS_FILTER_BASE + 7'h10, d);
		chk(d, KEY1[31:24]);
		frame(0, 1'b0);
		status;
		head;
		frame(0, 1'b1);
		frame(3, 1'b0);
		status;
		frame(1, 1'b0);
		frame(2, 1'b0);
		status;
		frame(0, 1'b0);
		status;
		repeat (3) begin
			head;
			rel;
			status;
		end
		head;
		wr(OFS_QSTAT, 8'h18);
		ovr = 0;
		full = 0;
		wr(OFS_MASTER_CTRL, 8'h01);
		lock = 1;
		frame(0, 1'b0);
		frame(1, 1'b0);
		frame(2, 1'b0);
		frame(0, 1'b0);
		status;
		repeat (3) begin
			head;
			rel;
		end
		wr(OFS_IRQ_EN, 8'h00);
		ie = 0;
		frame(2, 1'b0);
		status;
		rel;
		wr(OFS_IRQ_EN, 8'h07);
		ie = 1;
		// A write while the enable is low must leave the state frozen
		ce_i <= 1'b0;
		wr(OFS_IRQ_EN, 8'h00);
		ce_i <= 1'b1;
		status;
		for (k = 0; k < 40; k++) begin
			if (k % 10 == 0) begin
				lock = $urandom % 2;
				wr(OFS_MASTER_CTRL, 8'(lock));
			end
			if ($urandom % 3 == 0) rel;
			else frame($urandom % 4, $urandom % 8 == 0);
			status;
			head;
		end
		test_done;
	end
endmodule
`default_nettype wire
